// *** rtl/tmw_mode_ctrl.sv ***
// Our own choices: the APB register port and the address map.
`timescale 1ns/10ps
//
// Operation
// (RL1) Pin modes need I/O supply
// (RL2) Sleep: B rise to Normal/Receive-only
// (RL3) Sleep stays without B rise
// (RL4) Sleep to Stand-by only by wake
// (RL5) Reset: functions off, outputs float
// (RL6) Reset: supply control follows supplies
// (RL7) Both supplies low: reset
// (RL8) Supply good: Stand-by, flag set
// (RL9) Bias follows silence timer only; the code also sets mid bias in active modes and on bus wake
// (RL10) Low power, silent bus: ground bias
// (RL11) Bus wake: mid bias
// (RL12) Wake in Sleep: Stand-by
// (RL13) Dominant, recessive, dominant in window
// (RL14) Pattern dropped on mode, timeout, reset
// (RL15) Local wake: both edges, battery good
// (RL16) Local spikes ignored
// (RL17) Local wake in Sleep: supply on
// (RL18) Low power, no wake: outputs high
// (RL19) Bus wake both low; local receive low
// (RL20) Bus wake has precedence
// (RL21) Host: Receive-only a low b high
// (RL22) Host: Go-to-Sleep b low a high
// (RL23) Go-to-Sleep expiry, clean: Sleep
// (RL24) Timers are counters with parameters
// (RL25) Wake held until active mode/reset
module tmw_mode_ctrl #(
    parameter int WIN_CYC = tmw_pkg::WAKE_WIN_CYC,
    parameter int SIL_CYC = tmw_pkg::SILENCE_CYC,
    parameter int PON_CYC = tmw_pkg::PON_CYC,
    parameter int FILT_CYC = tmw_pkg::WAKE_FILT_CYC,
    parameter int GTS_CYC = tmw_pkg::SLEEP_CYC,
    parameter int LWF_CYC = tmw_pkg::LWF_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Host mode pins
    input wire logic mode_select_pin_a,
    input wire logic mode_select_pin_b,
    // Bus and local wake
    input wire logic bus_dominant,
    input wire logic local_edge_input,
    // Supply comparators
    input wire logic vbat_above_pod,
    input wire logic vbat_above_uv,
    input wire logic vcc_above_uv,
    input wire logic vio_above_uv,
    // Host outputs
    output logic rxd_out,
    output logic rxd_oe,
    output logic diag_flag_out,
    output logic diag_flag_oe,
    // Supply control, bias and function enables
    output logic supply_control_out,
    output logic [1:0] bias_mode,
    output logic tx_enable,
    output logic rx_enable
);
    localparam int CW = tmw_pkg::CNT_W;
    localparam logic [CW-1:0] WIN_MAX = CW'(WIN_CYC);
    localparam logic [CW-1:0] SIL_MAX = CW'(SIL_CYC);
    localparam logic [CW-1:0] PON_LAST = CW'(PON_CYC - 1);
    localparam logic [CW-1:0] FILT_MAX = CW'(FILT_CYC);
    localparam logic [CW-1:0] GTS_MAX = CW'(GTS_CYC);

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    wire [tmw_pkg::NPIN-1:0] raw_pins;
    wire [tmw_pkg::NPIN-1:0] pin_s;
    wire [tmw_pkg::NPIN-1:0] pin_chg;
    wire lwu_lvl;
    wire lwu_chg;

    assign raw_pins = {vio_above_uv, vcc_above_uv, vbat_above_uv, vbat_above_pod,
                       bus_dominant, mode_select_pin_b, mode_select_pin_a};

    // Every pin from outside crosses three flops
    genvar gi;
    generate
        for (gi = 0; gi < tmw_pkg::NPIN; gi++) begin : g_sync
            tmw_sync_filter #(.FILT_CYC(1), .CW(tmw_pkg::SYNC_CW)) u_sync (
                .pclk(pclk),
                .presetn(presetn),
                .pin(raw_pins[gi]),
                .level(pin_s[gi]),
                .change(pin_chg[gi])
            );
        end
    endgenerate

    // Local wake pin with spike filter
    tmw_sync_filter #(.FILT_CYC(LWF_CYC), .CW(tmw_pkg::SYNC_CW)) u_lwu ( // RL16
        .pclk(pclk),
        .presetn(presetn),
        .pin(local_edge_input),
        .level(lwu_lvl),
        .change(lwu_chg)
    );

    ////////////////////////////////////////////////////////////////////
    // State and qualifiers
    tmw_pkg::tmw_mode_t mode_r, mode_nxt;
    tmw_pkg::tmw_wup_t wp_r, wp_nxt;
    tmw_pkg::tmw_bias_t bias_r, bias_nxt;
    logic [CW-1:0] pon_cnt_r, gts_cnt_r, sil_cnt_r, ph_cnt_r, win_cnt_r;
    logic b_prev_r, por_flag_r, wup_pend_r, lwu_pend_r;
    logic rxd_r, rxd_oe_r, diag_r, diag_oe_r, supply_r;
    logic [31:0] prdata_r;

    wire bus_d = pin_s[tmw_pkg::PIN_BUS];
    wire vbat_pod_ok = pin_s[tmw_pkg::PIN_VBAT_POD];
    wire vbat_uv_ok = pin_s[tmw_pkg::PIN_VBAT_UV];
    wire vcc_ok = pin_s[tmw_pkg::PIN_VCC_UV];
    wire pin_ok = pin_s[tmw_pkg::PIN_VIO_UV];
    // Inputs blocked in reset or low I/O supply
    wire in_por = mode_r == tmw_pkg::MD_POR;
    wire pin_a = pin_s[tmw_pkg::PIN_A] && pin_ok && !in_por; // RL1 RL5
    wire pin_b = pin_s[tmw_pkg::PIN_B] && pin_ok && !in_por; // RL1 RL5
    wire b_rise = pin_b && !b_prev_r;
    wire por_enter = !vbat_pod_ok && !vcc_ok; // RL7
    wire supply_ok = vbat_uv_ok || vcc_ok;
    wire act_mode = (mode_r == tmw_pkg::MD_NORM) || (mode_r == tmw_pkg::MD_RXO);
    wire lp_mode = !act_mode && !in_por;
    wire gts_exp = gts_cnt_r == GTS_MAX;
    wire sil_exp = sil_cnt_r == SIL_MAX;
    wire ph_ok = ph_cnt_r == FILT_MAX;
    wire win_exp = win_cnt_r == WIN_MAX;
    wire wp_abort = !lp_mode || por_enter || win_exp; // RL14
    wire wup_det = (wp_r == tmw_pkg::WP_DOM2) && ph_ok && !wp_abort; // RL13
    wire lwu_det = lwu_chg && vbat_uv_ok && lp_mode; // RL15
    wire wake_det = wup_det || lwu_det;
    wire wake_any = wup_pend_r || lwu_pend_r || wake_det;
    wire pon_done = supply_ok && (pon_cnt_r == PON_LAST);
    wire pend_clr = !lp_mode;

    ////////////////////////////////////////////////////////////////////
    // Mode sequencing
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            tmw_pkg::MD_POR: begin
                if (pon_done)
                    mode_nxt = tmw_pkg::MD_STBY; // RL8
            end
            tmw_pkg::MD_STBY, tmw_pkg::MD_NORM, tmw_pkg::MD_RXO: begin
                if (pin_ok) begin // RL1
                    if (pin_b)
                        mode_nxt = pin_a ? tmw_pkg::MD_NORM : tmw_pkg::MD_RXO; // RL21
                    else
                        mode_nxt = pin_a ? tmw_pkg::MD_GTS : tmw_pkg::MD_STBY; // RL22
                end
            end
            tmw_pkg::MD_GTS: begin
                if (pin_ok && pin_b)
                    mode_nxt = pin_a ? tmw_pkg::MD_NORM : tmw_pkg::MD_RXO;
                else if (pin_ok && !pin_a && !gts_exp)
                    mode_nxt = tmw_pkg::MD_STBY;
                else if (gts_exp && !wake_any && !por_flag_r)
                    mode_nxt = tmw_pkg::MD_SLEEP; // RL23
            end
            tmw_pkg::MD_SLEEP: begin
                // Host edge beats a same-cycle wake
                if (b_rise)
                    mode_nxt = pin_a ? tmw_pkg::MD_NORM : tmw_pkg::MD_RXO; // RL2
                else if (wake_det)
                    mode_nxt = tmw_pkg::MD_STBY; // RL4 RL12 RL17
                else
                    mode_nxt = tmw_pkg::MD_SLEEP; // RL3
            end
            default: mode_nxt = tmw_pkg::MD_POR;
        endcase
        if (por_enter)
            mode_nxt = tmw_pkg::MD_POR; // RL7
    end

    // Mode register and mode timers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= tmw_pkg::MD_POR;
            b_prev_r <= 1'b0;
            pon_cnt_r <= '0;
            gts_cnt_r <= '0;
        end else begin
            mode_r <= mode_nxt;
            b_prev_r <= pin_b;
            pon_cnt_r <= (in_por && supply_ok && !pon_done) ? pon_cnt_r + 1'b1 : '0; // RL24
            gts_cnt_r <= (mode_r == tmw_pkg::MD_GTS && mode_nxt == tmw_pkg::MD_GTS) ?
                         (gts_exp ? gts_cnt_r : gts_cnt_r + 1'b1) : '0;
        end
    end

    // Power-on flag; set wins over clear
    wire por_clr = psel && penable && pwrite && (paddr == tmw_pkg::CTRL_OFS) &&
                   pwdata[tmw_pkg::CTRL_POR_CLR_BIT];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            por_flag_r <= 1'b0;
        else if (in_por && pon_done)
            por_flag_r <= 1'b1; // RL8
        else if (por_clr)
            por_flag_r <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // Bus wake pattern detector
    always_comb begin
        wp_nxt = wp_r;
        case (wp_r)
            tmw_pkg::WP_IDLE: if (bus_d && lp_mode) wp_nxt = tmw_pkg::WP_DOM1;
            tmw_pkg::WP_DOM1: if (!bus_d) wp_nxt = ph_ok ? tmw_pkg::WP_REC : tmw_pkg::WP_IDLE;
            tmw_pkg::WP_REC: if (bus_d) wp_nxt = ph_ok ? tmw_pkg::WP_DOM2 : tmw_pkg::WP_IDLE;
            tmw_pkg::WP_DOM2: begin
                if (ph_ok || !bus_d)
                    wp_nxt = tmw_pkg::WP_IDLE;
            end
            default: wp_nxt = tmw_pkg::WP_IDLE;
        endcase
        if (wp_abort)
            wp_nxt = tmw_pkg::WP_IDLE; // RL14
    end

    // Phase and window counters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_r <= tmw_pkg::WP_IDLE;
            ph_cnt_r <= '0;
            win_cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            ph_cnt_r <= (wp_nxt != wp_r || ph_ok) ? (ph_ok && wp_nxt == wp_r ?
                        ph_cnt_r : '0) : ph_cnt_r + 1'b1; // RL13
            win_cnt_r <= (wp_nxt == tmw_pkg::WP_IDLE) ? '0 : win_cnt_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Wake pending flags; hardware set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wup_pend_r <= 1'b0;
            lwu_pend_r <= 1'b0;
        end else begin
            wup_pend_r <= wup_det || (wup_pend_r && !pend_clr); // RL25
            lwu_pend_r <= lwu_det || (lwu_pend_r && !pend_clr); // RL25
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Bias; silence timer starts expired, so ground after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            sil_cnt_r <= SIL_MAX;
        else if (pin_chg[tmw_pkg::PIN_BUS] && !in_por)
            sil_cnt_r <= '0; // RL9
        else if (in_por)
            sil_cnt_r <= SIL_MAX;
        else if (!sil_exp)
            sil_cnt_r <= sil_cnt_r + 1'b1;
    end

    always_comb begin
        bias_nxt = bias_r;
        if (in_por)
            bias_nxt = tmw_pkg::BIAS_FLOAT; // RL5
        else if (act_mode || wup_det)
            bias_nxt = tmw_pkg::BIAS_HALF; // RL11
        else if (sil_exp)
            bias_nxt = tmw_pkg::BIAS_GND; // RL10
    end

    ////////////////////////////////////////////////////////////////////
    // Host outputs and supply control
    wire rxd_nxt = act_mode ? !bus_d : !(wup_pend_r || lwu_pend_r); // RL18 RL19
    wire diag_nxt = act_mode ? 1'b1 : !wup_pend_r; // RL19 RL20
    wire gts_off = (mode_r == tmw_pkg::MD_GTS) && gts_exp && !wake_any && !por_flag_r;
    wire supply_nxt = in_por ? (vbat_pod_ok || vcc_ok) : // RL6
                      !((mode_r == tmw_pkg::MD_SLEEP) || gts_off); // RL17

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxd_r <= 1'b1;
            rxd_oe_r <= 1'b0;
            diag_r <= 1'b1;
            diag_oe_r <= 1'b0;
            supply_r <= 1'b0;
            bias_r <= tmw_pkg::BIAS_FLOAT;
        end else begin
            rxd_r <= in_por ? 1'b1 : rxd_nxt;
            rxd_oe_r <= !in_por; // RL5
            diag_r <= in_por ? 1'b1 : diag_nxt;
            diag_oe_r <= !in_por; // RL5
            supply_r <= supply_nxt;
            bias_r <= bias_nxt;
        end
    end

    assign rxd_out = rxd_r;
    assign rxd_oe = rxd_oe_r;
    assign diag_flag_out = diag_r;
    assign diag_flag_oe = diag_oe_r;
    assign supply_control_out = supply_r;
    assign bias_mode = bias_r;
    assign tx_enable = mode_r == tmw_pkg::MD_NORM;
    assign rx_enable = act_mode;

    ////////////////////////////////////////////////////////////////////
    // APB: no wait states, read data latched at setup
    wire hit_ctrl = paddr == tmw_pkg::CTRL_OFS;
    wire hit_stat = paddr == tmw_pkg::STAT_OFS;
    wire [31:0] stat_word = {24'h000000, bias_r, lwu_pend_r, wup_pend_r,
                             por_flag_r, mode_r};
    wire [31:0] rd_mux = hit_stat ? stat_word : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata_r <= 32'h00000000;
        else if (psel && !penable)
            prdata_r <= rd_mux;
    end

    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(hit_ctrl || hit_stat);

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_por_entry; // RL7
        por_enter |=> mode_r == tmw_pkg::MD_POR;
    endproperty
    a_por_entry: assert property (p_por_entry) else $error("no reset");

    property p_por_outputs; // RL5
        in_por |=> !rxd_oe && !diag_flag_oe && bias_mode == tmw_pkg::BIAS_FLOAT;
    endproperty
    a_por_outputs: assert property (p_por_outputs) else $error("reset outputs");

    property p_sleep_stays; // RL3
        mode_r == tmw_pkg::MD_SLEEP && !b_rise && !wake_det && !por_enter
            |=> mode_r == tmw_pkg::MD_SLEEP;
    endproperty
    a_sleep_stays: assert property (p_sleep_stays) else $error("left sleep");

    property p_sleep_edge; // RL2
        mode_r == tmw_pkg::MD_SLEEP && b_rise && !por_enter
            |=> mode_r == ($past(pin_a) ? tmw_pkg::MD_NORM : tmw_pkg::MD_RXO);
    endproperty
    a_sleep_edge: assert property (p_sleep_edge) else $error("sleep edge");

    property p_sleep_wake; // RL12
        mode_r == tmw_pkg::MD_SLEEP && wake_det && !b_rise && !por_enter
            |=> mode_r == tmw_pkg::MD_STBY;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake");

    sequence s_gts_done;
        mode_r == tmw_pkg::MD_GTS && gts_exp && !wake_any && !por_flag_r;
    endsequence
    property p_gts_sleep; // RL23
        s_gts_done ##0 (!por_enter && !(pin_ok && pin_b)) |=> mode_r == tmw_pkg::MD_SLEEP;
    endproperty
    a_gts_sleep: assert property (p_gts_sleep) else $error("no sleep");

    property p_wup_out; // RL20
        lp_mode && wup_pend_r |=> !rxd_out && !diag_flag_out;
    endproperty
    a_wup_out: assert property (p_wup_out) else $error("bus wake pins");

    property p_lwu_out; // RL19
        lp_mode && lwu_pend_r && !wup_pend_r |=> !rxd_out && diag_flag_out;
    endproperty
    a_lwu_out: assert property (p_lwu_out) else $error("local wake pins");

    property p_wup_bias; // RL11
        wup_det |=> bias_mode == tmw_pkg::BIAS_HALF;
    endproperty
    a_wup_bias: assert property (p_wup_bias) else $error("bias not raised");

    property p_abort; // RL14
        !lp_mode |=> wp_r == tmw_pkg::WP_IDLE;
    endproperty
    a_abort: assert property (p_abort) else $error("pattern kept in active mode");

    property p_pon_flag; // RL8
        in_por ##1 mode_r == tmw_pkg::MD_STBY |-> por_flag_r;
    endproperty
    a_pon_flag: assert property (p_pon_flag) else $error("no reset flag");
endmodule

// *** inc/tmw_pkg.sv ***
package tmw_pkg;
    // Clock and timing figures
    localparam int CLK_NS = 50;
    localparam int WAKE_FILT_NS = 500;
    localparam int WAKE_FILT_CYC = (WAKE_FILT_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAKE_WIN_US = 1000;
    localparam int WAKE_WIN_CYC = WAKE_WIN_US * 1000 / CLK_NS;
    localparam int SILENCE_US = 1000000;
    localparam int SILENCE_CYC = SILENCE_US * 1000 / CLK_NS;
    localparam int PON_US = 340;
    localparam int PON_CYC = PON_US * 1000 / CLK_NS;
    localparam int SLEEP_US = 50;
    localparam int SLEEP_CYC = SLEEP_US * 1000 / CLK_NS;
    localparam int LWF_US = 50;
    localparam int LWF_CYC = (LWF_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 25;
    localparam int SYNC_CW = 16;

    // Register map
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam int CTRL_POR_CLR_BIT = 0;

    // Pin synchroniser slots
    localparam int PIN_A = 0;
    localparam int PIN_B = 1;
    localparam int PIN_BUS = 2;
    localparam int PIN_VBAT_POD = 3;
    localparam int PIN_VBAT_UV = 4;
    localparam int PIN_VCC_UV = 5;
    localparam int PIN_VIO_UV = 6;
    localparam int NPIN = 7;

    typedef enum logic [2:0] {
        MD_POR = 3'h0, MD_STBY = 3'h1, MD_NORM = 3'h3,
        MD_RXO = 3'h2, MD_GTS = 3'h6, MD_SLEEP = 3'h7
    } tmw_mode_t;

    typedef enum logic [1:0] {
        WP_IDLE = 2'h0, WP_DOM1 = 2'h1, WP_REC = 2'h3, WP_DOM2 = 2'h2
    } tmw_wup_t;

    typedef enum logic [1:0] {
        BIAS_FLOAT = 2'h0, BIAS_GND = 2'h1, BIAS_HALF = 2'h2
    } tmw_bias_t;
endpackage

// *** rtl/tmw_sync_filter.sv ***
`timescale 1ns/10ps
// Three-flop synchroniser with stability filter
module tmw_sync_filter #(
    parameter int FILT_CYC = 1,
    parameter int CW = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Raw pin
    input wire logic pin,
    // Filtered level and one-cycle change pulse
    output logic level,
    output logic change
);
    localparam logic [CW-1:0] LAST = CW'(FILT_CYC - 1);

    logic [2:0] sync_r;
    logic [CW-1:0] cnt_r;
    logic lvl_r;
    logic chg_r;
    wire agree;
    wire differ;
    wire done;
    wire [CW-1:0] cnt_nxt;

    // Stage one may be metastable; never read
    assign agree = sync_r[1] == sync_r[2];
    assign differ = agree && (sync_r[2] != lvl_r);
    assign done = differ && (cnt_r == LAST);
    assign cnt_nxt = (differ && !done) ? cnt_r + 1'b1 : '0;

    // New level must hold FILT_CYC cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_r <= 3'h0;
            cnt_r <= '0;
            lvl_r <= 1'b0;
            chg_r <= 1'b0;
        end else begin
            sync_r <= {sync_r[1:0], pin};
            cnt_r <= cnt_nxt;
            lvl_r <= done ? sync_r[2] : lvl_r;
            chg_r <= done;
        end
    end

    assign level = lvl_r;
    assign change = chg_r;
endmodule

// *** verification/tmw_host_model.sv ***
`timescale 1ns/10ps
// Host pins and bus
module tmw_host_model (
    // Clock
    input wire logic pclk,
    // Host mode pins
    output logic mode_select_pin_a,
    output logic mode_select_pin_b,
    // Bus state and local wake pin
    output logic bus_dominant,
    output logic local_edge_input
);
    ////////////////////////////////////////////////////////////////////////////
    // Idle levels: pins pulled low, bus recessive
    initial begin
        mode_select_pin_a = 1'b0;
        mode_select_pin_b = 1'b0;
        bus_dominant = 1'b0;
        local_edge_input = 1'b0;
    end

    // Both mode pins change on one edge
    task automatic set_mode(input logic a, input logic b);
        @(posedge pclk);
        mode_select_pin_a <= a;
        mode_select_pin_b <= b;
    endtask

    // One bus phase held for n cycles
    task automatic bus_phase(input logic dom, input int n);
        @(posedge pclk);
        bus_dominant <= dom;
        repeat (n - 1) @(posedge pclk);
    endtask

    // Dominant, recessive, dominant; bus handed back recessive
    task automatic wake_pattern(input int n1, input int n2, input int n3);
        bus_phase(1'b1, n1);
        bus_phase(1'b0, n2);
        bus_phase(1'b1, n3);
        bus_phase(1'b0, 1);
    endtask

    // Local pin level held for n cycles
    task automatic local_level(input logic v, input int n);
        @(posedge pclk);
        local_edge_input <= v;
        repeat (n - 1) @(posedge pclk);
    endtask
endmodule

// *** verification/tb.sv ***
`timescale 1ns/10ps
module tb;
    localparam int WIN = 40;
    localparam int FILT = 3;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic mode_select_pin_a, mode_select_pin_b, bus_dominant, local_edge_input;
    logic vbat_above_pod, vbat_above_uv, vcc_above_uv, vio_above_uv;
    logic rxd_out, rxd_oe, diag_flag_out, diag_flag_oe, supply_control_out;
    logic tx_enable, rx_enable;
    logic [1:0] bias_mode;
    logic [1:0] pins [3] = '{2'b11, 2'b01, 2'b00};
    int fail_count = 0;
    int compares = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Design, host and bus model
    tmw_mode_ctrl #(.WIN_CYC(WIN), .SIL_CYC(50), .PON_CYC(20), .FILT_CYC(FILT),
        .GTS_CYC(30), .LWF_CYC(5)) i_tmw_mode_ctrl (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mode_select_pin_a(mode_select_pin_a), .mode_select_pin_b(mode_select_pin_b),
        .bus_dominant(bus_dominant), .local_edge_input(local_edge_input),
        .vbat_above_pod(vbat_above_pod), .vbat_above_uv(vbat_above_uv),
        .vcc_above_uv(vcc_above_uv), .vio_above_uv(vio_above_uv), .rxd_out(rxd_out),
        .rxd_oe(rxd_oe), .diag_flag_out(diag_flag_out), .diag_flag_oe(diag_flag_oe),
        .supply_control_out(supply_control_out), .bias_mode(bias_mode),
        .tx_enable(tx_enable), .rx_enable(rx_enable));
    tmw_host_model i_tmw_host_model (.pclk(pclk), .mode_select_pin_a(mode_select_pin_a),
        .mode_select_pin_b(mode_select_pin_b), .bus_dominant(bus_dominant),
        .local_edge_input(local_edge_input));

    // 20 MHz clock
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Expected {receive data, diag} in low power modes
    function automatic logic [1:0] wake_pins(input logic bw, input logic lw);
        return {~(bw | lw), ~bw};
    endfunction

    // Mode that a pin pair asks for
    function automatic tmw_pkg::tmw_mode_t pin_mode(input logic a, input logic b);
        return b ? (a ? tmw_pkg::MD_NORM : tmw_pkg::MD_RXO)
                 : (a ? tmw_pkg::MD_GTS : tmw_pkg::MD_STBY);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t mismatch got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // APB transfer, result in rd and err
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Poll status for a mode
    task automatic wait_mode(input tmw_pkg::tmw_mode_t m, input int lim);
        int n;
        n = 0;
        do begin
            apb(1'b0, tmw_pkg::STAT_OFS, 32'h0);
            n++;
        end while (rd[2:0] !== m && n <= lim);
    endtask

    // Normal, Go-to-Sleep, Sleep
    task automatic to_sleep();
        i_tmw_host_model.set_mode(1'b1, 1'b1);
        wait_mode(tmw_pkg::MD_NORM, 20);
        i_tmw_host_model.set_mode(1'b1, 1'b0);
        wait_mode(tmw_pkg::MD_SLEEP, 40);
        chk(rd[2:0], tmw_pkg::MD_SLEEP);
        chk(supply_control_out, 1'b0);
        i_tmw_host_model.set_mode(1'b0, 1'b0);
        repeat (12) @(posedge pclk);
        wait_mode(tmw_pkg::MD_SLEEP, 0);
        chk(rd[2:0], tmw_pkg::MD_SLEEP);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        print_verdict();
    end

    // Main sequence
    initial begin
        int n1, n2, n3;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {vbat_above_pod, vbat_above_uv, vcc_above_uv, vio_above_uv} = 4'hF;
        n1 = $urandom(66);
        repeat (8) @(posedge pclk);
        @(negedge pclk);
        chk({rxd_oe, diag_flag_oe}, 2'b00);
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        wait_mode(tmw_pkg::MD_STBY, 30);
        chk(rd[3:0], {1'b1, tmw_pkg::MD_STBY});
        @(negedge pclk);
        chk({rxd_oe, rxd_out, diag_flag_oe, diag_flag_out}, 4'hF);
        chk(supply_control_out, 1'b1);
        // Unmapped refused; flag cleared
        apb(1'b1, 8'h08, 32'hFFFFFFFF);
        chk(err, 1'b1);
        apb(1'b0, 8'h08, 32'h0);
        chk({err, rd[30:0]}, {1'b1, 31'h0});
        apb(1'b1, tmw_pkg::CTRL_OFS, 32'h1);
        apb(1'b0, tmw_pkg::CTRL_OFS, 32'h0);
        chk({err, rd[30:0]}, 32'h0);
        wait_mode(tmw_pkg::MD_STBY, 0);
        chk(rd[3], 1'b0);
        // Pin-commanded modes
        foreach (pins[i]) begin
            i_tmw_host_model.set_mode(pins[i][1], pins[i][0]);
            wait_mode(pin_mode(pins[i][1], pins[i][0]), 20);
            chk(rd[2:0], pin_mode(pins[i][1], pins[i][0]));
            @(negedge pclk);
            chk({tx_enable, rx_enable}, {&pins[i], pins[i][0]});
        end
        // Pins blocked while the I/O supply is low
        vio_above_uv <= 1'b0;
        i_tmw_host_model.set_mode(1'b1, 1'b1);
        repeat (20) @(posedge pclk);
        wait_mode(tmw_pkg::MD_STBY, 0);
        chk(rd[2:0], tmw_pkg::MD_STBY);
        vio_above_uv <= 1'b1;
        wait_mode(tmw_pkg::MD_NORM, 20);
        chk(bias_mode, tmw_pkg::BIAS_HALF);
        // Sleep, silent bus; pin B edge with A low leaves for Receive-only
        to_sleep();
        chk(bias_mode, tmw_pkg::BIAS_GND);
        i_tmw_host_model.set_mode(1'b0, 1'b1);
        wait_mode(tmw_pkg::MD_RXO, 20);
        chk(rd[2:0], tmw_pkg::MD_RXO);
        // Spike, low-battery edge, real edge
        to_sleep();
        i_tmw_host_model.local_level(1'b1, 2);
        i_tmw_host_model.local_level(1'b0, 15);
        vbat_above_uv <= 1'b0;
        repeat (6) @(posedge pclk);
        i_tmw_host_model.local_level(1'b1, 15);
        wait_mode(tmw_pkg::MD_SLEEP, 0);
        chk(rd[2:0], tmw_pkg::MD_SLEEP);
        vbat_above_uv <= 1'b1;
        repeat (6) @(posedge pclk);
        i_tmw_host_model.local_level(1'b0, 15);
        wait_mode(tmw_pkg::MD_STBY, 10);
        chk(rd[2:0], tmw_pkg::MD_STBY);
        @(negedge pclk);
        chk({rxd_out, diag_flag_out, supply_control_out}, {wake_pins(0, 1), 1'b1});
        i_tmw_host_model.wake_pattern(6, 6, 6);
        repeat (4) @(posedge pclk);
        @(negedge pclk);
        chk({rxd_out, diag_flag_out}, wake_pins(1, 1));
        chk(bias_mode, tmw_pkg::BIAS_HALF);
        wait_mode(tmw_pkg::MD_STBY, 0);
        chk(rd[5:4], 2'b11);
        i_tmw_host_model.set_mode(1'b1, 1'b1);
        wait_mode(tmw_pkg::MD_NORM, 20);
        chk(rd[5:4], 2'b00);
        // Pattern too slow for the window is dropped
        i_tmw_host_model.set_mode(1'b0, 1'b0);
        wait_mode(tmw_pkg::MD_STBY, 20);
        i_tmw_host_model.bus_phase(1'b1, 6);
        i_tmw_host_model.bus_phase(1'b0, WIN + 6);
        i_tmw_host_model.wake_pattern(6, 1, 1);
        repeat (6) @(posedge pclk);
        wait_mode(tmw_pkg::MD_STBY, 0);
        chk(rd[5:4], 2'b00);
        // Sleep, random pattern timing above the filter
        to_sleep();
        n1 = FILT + 2 + $urandom_range(0, 3);
        n2 = FILT + 2 + $urandom_range(0, 3);
        n3 = FILT + 2 + $urandom_range(0, 3);
        i_tmw_host_model.wake_pattern(n1, n2, n3);
        wait_mode(tmw_pkg::MD_STBY, 10);
        chk(rd[5:0], {2'b01, 1'b0, tmw_pkg::MD_STBY});
        @(negedge pclk);
        chk({rxd_out, diag_flag_out}, wake_pins(1, 0));
        // Both supplies gone, then core supply back
        vbat_above_pod <= 1'b0;
        vcc_above_uv <= 1'b0;
        repeat (8) @(posedge pclk);
        @(negedge pclk);
        chk({rxd_oe, diag_flag_oe, tx_enable, rx_enable, supply_control_out}, 5'h0);
        chk(bias_mode, tmw_pkg::BIAS_FLOAT);
        wait_mode(tmw_pkg::MD_POR, 0);
        chk(rd[5:0], {2'b00, 1'b0, tmw_pkg::MD_POR});
        vcc_above_uv <= 1'b1;
        repeat (6) @(posedge pclk);
        chk(supply_control_out, 1'b1);
        wait_mode(tmw_pkg::MD_STBY, 20);
        chk(rd[3:0], {1'b1, tmw_pkg::MD_STBY});
        print_verdict();
    end
endmodule
